/* File: src/eapi_flags.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: control bit 7 is line b priority, one high, zero low.
// RULE2: control bit 6 is line a priority, one high, zero low.
// RULE3: control bits 5 and 2 read zero and ignore writes.
// RULE4: control bit 4 enables line b requests.
// RULE5: control bit 3 enables line a requests.
// RULE6: control bit 1 set by line b event, held until written zero.
// RULE7: control bit 0 set by line a event, held until written zero.
// RULE8: flags set regardless of their enable and the global enable.
// RULE9: software clears a flag before enabling it and after servicing.
// RULE10: flag bit 7 set by parallel port access; reserved without that port.
// RULE11: flag bit 6 set when a conversion completes, software clears it.
// RULE12: flag bit 5 read-only, follows receive buffer full.
// RULE13: flag bit 4 read-only, follows transmit buffer empty.
// RULE14: flag bit 3 set when sync serial transfer finishes.
// RULE15: flag bit 2 set on capture or compare match, unused in pwm.
// RULE16: flag bit 1 set on timer b period match.
// RULE17: flag bit 0 set on timer a overflow, cleared by writing zero.
// RULE18: priority mode off ignores priority bits, one common vector.
// RULE19: line edges chosen by edge-select bit, one rising, zero falling.
// RULE20: a set in the same cycle as a clear leaves the flag set.
// RULE21: request raised when flag and enable are one, tagged with priority.
module eapi_flags
	import eapi_pkg::*;
#(
	parameter bit PSP_PRESENT = 1'b1
)
(
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic [ADDR_W-1:0]    regAddr,
	input  wire logic [DATA_W-1:0]    regWrData,
	input  wire logic                 regWrStb,
	input  wire logic                 regRdStb,
	output logic      [DATA_W-1:0]    regRdData,
	input  wire logic                 extLineA,
	input  wire logic                 extLineB,
	input  wire eapi_periph_ev_t      periphEv,
	input  wire logic [7:0]           periphEnable,
	input  wire logic [7:0]           periphPriority,
	output logic      [NUM_SRC-1:0]   reqPending,
	output logic      [NUM_SRC-1:0]   reqHigh,
	output logic                      coreIrqHigh,
	output logic                      coreIrqLow,
	output logic      [23:0]          vectorAddr
);

	function automatic logic hitWrite(input logic [ADDR_W-1:0] ofs);
		hitWrite = regWrStb && (regAddr == ofs);
	endfunction : hitWrite

	// keeps a flag set when its event lands in the clearing cycle
	function automatic logic nextFlag(
		input logic cur,
		input logic wrHit,
		input logic wrBit,
		input logic setEv
	);
		nextFlag = (wrHit ? wrBit : cur) | setEv;
	endfunction : nextFlag

	// one-cycle edge on a synchronised line, polarity from its select bit
	function automatic logic lineEdge(
		input logic cur,
		input logic prev,
		input logic rising
	);
		lineEdge = rising ? (cur & ~prev) : (~cur & prev);
	endfunction : lineEdge

	logic                 rstMeta_reg;
	logic                 rstSync_reg;
	logic                 rstN;

	logic [DATA_W-1:0]    ctrlThree_reg;
	logic [DATA_W-1:0]    ctrlThree_next;
	logic [DATA_W-1:0]    flagsOne_reg;
	logic [DATA_W-1:0]    flagsOne_next;
	logic [DATA_W-1:0]    config_reg;
	logic [DATA_W-1:0]    rdData_reg;
	logic [DATA_W-1:0]    rdData_next;

	logic [1:0]           lineMeta_reg;
	logic [1:0]           lineSync_reg;
	logic [1:0]           linePrev_reg;
	logic                 edgeA;
	logic                 edgeB;
	logic [2:0]           armPipe_reg;

	logic                 wrCtrl;
	logic                 wrFlags;
	logic                 ccpSet;
	eapi_ccp_mode_t       ccpMode;

	logic [NUM_SRC-1:0]   flagVec;
	logic [NUM_SRC-1:0]   enVec;
	logic [NUM_SRC-1:0]   prioVec;
	logic [NUM_SRC-1:0]   pend_next;
	logic [NUM_SRC-1:0]   high_next;
	logic [NUM_SRC-1:0]   pending_reg;
	logic [NUM_SRC-1:0]   high_reg;
	logic                 irqHigh_reg;
	logic                 irqLow_reg;
	logic [23:0]          vector_reg;
	logic                 prioMode;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end
		else
		begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	assign rstN = rstSync_reg;

	// pins are asynchronous: two flops, then a third for the edge compare
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			lineMeta_reg <= 2'b00;
			lineSync_reg <= 2'b00;
			linePrev_reg <= 2'b00;
		end
		else
		begin
			lineMeta_reg <= {extLineB, extLineA};
			lineSync_reg <= lineMeta_reg;
			linePrev_reg <= lineSync_reg;
		end
	end

	// edges count only once the pin pipeline holds real samples, else a high pin fakes one
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			armPipe_reg <= 3'h0;
		end
		else
		begin
			armPipe_reg <= {armPipe_reg[1:0], 1'h1};
		end
	end

	// changing an edge select alone never looks like an edge, only a pin change makes one
	always_comb
	begin
		edgeA = armPipe_reg[2] & lineEdge(lineSync_reg[0], linePrev_reg[0], config_reg[BIT_A_EDGE]); // RULE19
		edgeB = armPipe_reg[2] & lineEdge(lineSync_reg[1], linePrev_reg[1], config_reg[BIT_B_EDGE]); // RULE19
	end

	assign wrCtrl  = hitWrite(OFS_CTRL_THREE);
	assign wrFlags = hitWrite(OFS_FLAGS_ONE);
	assign ccpMode = eapi_ccp_mode_t'(config_reg[BIT_CCP_MODE_LO +: 2]);
	assign prioMode = config_reg[BIT_PRIO_MODE];

	always_comb
	begin
		case (ccpMode)
			EAPI_CCP_CAPTURE: ccpSet = periphEv.capEvent; // RULE15
			EAPI_CCP_COMPARE: ccpSet = periphEv.cmpEvent; // RULE15
			EAPI_CCP_PWM:     ccpSet = 1'b0; // RULE15
			default:          ccpSet = 1'b0;
		endcase
	end

	always_comb
	begin
		ctrlThree_next = ctrlThree_reg;
		if (wrCtrl)
		begin
			ctrlThree_next[BIT_B_PRIO] = regWrData[BIT_B_PRIO]; // RULE1
			ctrlThree_next[BIT_A_PRIO] = regWrData[BIT_A_PRIO]; // RULE2
			ctrlThree_next[BIT_B_EN]   = regWrData[BIT_B_EN]; // RULE4
			ctrlThree_next[BIT_A_EN]   = regWrData[BIT_A_EN]; // RULE5
		end
		// flags ignore the enables so software can poll them
		ctrlThree_next[BIT_B_FLAG] = nextFlag(ctrlThree_reg[BIT_B_FLAG], wrCtrl,
		                                      regWrData[BIT_B_FLAG], edgeB); // RULE6 RULE8 RULE20
		ctrlThree_next[BIT_A_FLAG] = nextFlag(ctrlThree_reg[BIT_A_FLAG], wrCtrl,
		                                      regWrData[BIT_A_FLAG], edgeA); // RULE7 RULE8 RULE20
		ctrlThree_next = ctrlThree_next & CTRL_THREE_MASK; // RULE3
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			ctrlThree_reg <= CTRL_THREE_RST;
		end
		else
		begin
			ctrlThree_reg <= ctrlThree_next;
		end
	end

	always_comb
	begin
		flagsOne_next = flagsOne_reg;
		// without the parallel port the bit is tied low
		flagsOne_next[BIT_PSP] = PSP_PRESENT &
			nextFlag(flagsOne_reg[BIT_PSP], wrFlags, regWrData[BIT_PSP],
			         periphEv.pspAccess); // RULE10 RULE20
		flagsOne_next[BIT_CONV] = nextFlag(flagsOne_reg[BIT_CONV], wrFlags,
		                                   regWrData[BIT_CONV], periphEv.convDone); // RULE11 RULE20
		// buffer flags mirror the serial unit, software cannot write them
		flagsOne_next[BIT_RX] = periphEv.rxBufFull; // RULE12
		flagsOne_next[BIT_TX] = periphEv.txBufEmpty; // RULE13
		flagsOne_next[BIT_SSP] = nextFlag(flagsOne_reg[BIT_SSP], wrFlags,
		                                  regWrData[BIT_SSP], periphEv.syncSerialDone); // RULE14 RULE20
		flagsOne_next[BIT_CCP] = nextFlag(flagsOne_reg[BIT_CCP], wrFlags,
		                                  regWrData[BIT_CCP], ccpSet); // RULE15 RULE20
		flagsOne_next[BIT_TMRB] = nextFlag(flagsOne_reg[BIT_TMRB], wrFlags,
		                                   regWrData[BIT_TMRB], periphEv.timerBMatch); // RULE16 RULE20
		flagsOne_next[BIT_TMRA] = nextFlag(flagsOne_reg[BIT_TMRA], wrFlags,
		                                   regWrData[BIT_TMRA], periphEv.timerAOverflow); // RULE17 RULE20
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			flagsOne_reg <= FLAGS_ONE_RST;
		end
		else
		begin
			flagsOne_reg <= flagsOne_next; // RULE8
		end
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			config_reg <= CONFIG_RST;
		end
		else if (hitWrite(OFS_CONFIG))
		begin
			config_reg <= regWrData & CONFIG_MASK;
		end
	end

	// request vector: bits 9 and 8 are lines b and a, the rest peripherals
	always_comb
	begin
		flagVec = {ctrlThree_reg[BIT_B_FLAG], ctrlThree_reg[BIT_A_FLAG], flagsOne_reg};
		enVec   = {ctrlThree_reg[BIT_B_EN], ctrlThree_reg[BIT_A_EN], periphEnable};
		prioVec = {ctrlThree_reg[BIT_B_PRIO], ctrlThree_reg[BIT_A_PRIO], periphPriority};
		pend_next = flagVec & enVec; // RULE21
		high_next = pend_next & prioVec; // RULE21
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pending_reg <= '0;
			high_reg    <= '0;
		end
		else
		begin
			pending_reg <= pend_next;
			high_reg    <= high_next;
		end
	end

	// compatibility mode routes every request to one vector
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			irqHigh_reg <= 1'b0;
			irqLow_reg  <= 1'b0;
			vector_reg  <= VEC_HIGH;
		end
		else if (!prioMode)
		begin
			irqHigh_reg <= |pend_next; // RULE18
			irqLow_reg  <= 1'b0; // RULE18
			vector_reg  <= VEC_HIGH; // RULE18
		end
		else
		begin
			irqHigh_reg <= |high_next;
			irqLow_reg  <= |(pend_next & ~high_next);
			// idle stays on the high vector, only a lone low request moves it
			vector_reg  <= (|pend_next && !(|high_next)) ? VEC_LOW : VEC_HIGH;
		end
	end

	// read data stand for one cycle only, zero otherwise
	always_comb
	begin
		rdData_next = '0;
		if (regRdStb)
		begin
			case (regAddr)
				OFS_CTRL_THREE: rdData_next = ctrlThree_reg & CTRL_THREE_MASK; // RULE3
				OFS_FLAGS_ONE:  rdData_next = flagsOne_reg;
				OFS_CONFIG:     rdData_next = config_reg;
				OFS_STATUS:     rdData_next = {4'h0, irqHigh_reg, irqLow_reg,
				                               pending_reg[9:8]};
				default:        rdData_next = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rdData_reg <= '0;
		end
		else
		begin
			rdData_reg <= rdData_next;
		end
	end

	assign regRdData   = rdData_reg;
	assign reqPending  = pending_reg;
	assign reqHigh     = high_reg;
	assign coreIrqHigh = irqHigh_reg;
	assign coreIrqLow  = irqLow_reg;
	assign vectorAddr  = vector_reg;

endmodule : eapi_flags

`default_nettype wire

/* File: inc/eapi_pkg.sv */
package eapi_pkg;

	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          NUM_SRC         = 10;

	// register map
	localparam logic [7:0]  OFS_CTRL_THREE  = 8'h00;
	localparam logic [7:0]  OFS_FLAGS_ONE   = 8'h01;
	localparam logic [7:0]  OFS_CONFIG      = 8'h02;
	localparam logic [7:0]  OFS_STATUS      = 8'h03;

	// control register three fields
	localparam int          BIT_B_PRIO      = 7;
	localparam int          BIT_A_PRIO      = 6;
	localparam int          BIT_B_EN        = 4;
	localparam int          BIT_A_EN        = 3;
	localparam int          BIT_B_FLAG      = 1;
	localparam int          BIT_A_FLAG      = 0;
	localparam logic [7:0]  CTRL_THREE_MASK = 8'hDB;
	localparam logic [7:0]  CTRL_THREE_RST  = 8'hC0;

	// peripheral flag register one fields
	localparam int          BIT_PSP         = 7;
	localparam int          BIT_CONV        = 6;
	localparam int          BIT_RX          = 5;
	localparam int          BIT_TX          = 4;
	localparam int          BIT_SSP         = 3;
	localparam int          BIT_CCP         = 2;
	localparam int          BIT_TMRB        = 1;
	localparam int          BIT_TMRA        = 0;
	localparam logic [7:0]  FLAGS_ONE_RST   = 8'h00;

	// configuration register fields
	localparam int          BIT_PRIO_MODE   = 0;
	localparam int          BIT_A_EDGE      = 1;
	localparam int          BIT_B_EDGE      = 2;
	localparam int          BIT_CCP_MODE_LO = 3;
	localparam logic [7:0]  CONFIG_MASK     = 8'h1F;
	localparam logic [7:0]  CONFIG_RST      = 8'h06;

	localparam logic [23:0] VEC_HIGH        = 24'h00_0008;
	localparam logic [23:0] VEC_LOW         = 24'h00_0018;

	typedef enum logic [1:0]
	{
		EAPI_CCP_CAPTURE = 2'b00,
		EAPI_CCP_COMPARE = 2'b01,
		EAPI_CCP_PWM     = 2'b11
	} eapi_ccp_mode_t;

	typedef struct packed
	{
		logic pspAccess;
		logic convDone;
		logic rxBufFull;
		logic txBufEmpty;
		logic syncSerialDone;
		logic capEvent;
		logic cmpEvent;
		logic timerBMatch;
		logic timerAOverflow;
	} eapi_periph_ev_t;

endpackage : eapi_pkg

/* File: testbench/eapi_flags_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module eapi_flags_monitor
	import eapi_pkg::*;
(
	input wire logic                ref_clk,
	input wire logic                arst_n,
	input wire logic [ADDR_W-1:0]   regAddr,
	input wire logic                regRdStb,
	input wire logic [DATA_W-1:0]   regRdData,
	input wire eapi_periph_ev_t     periphEv,
	input wire logic [7:0]          periphEnable,
	input wire logic [7:0]          periphPriority,
	input wire logic [NUM_SRC-1:0]  reqPending,
	input wire logic [NUM_SRC-1:0]  reqHigh,
	input wire logic                coreIrqHigh,
	input wire logic                coreIrqLow,
	input wire logic [23:0]         vectorAddr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_rd(a);
		regRdStb && regAddr == a;
	endsequence
	// event in one cycle, enable present when the request register loads
	sequence s_evEn(ev, i);
		ev ##1 periphEnable[i];
	endsequence
	property p_ctrlRsvd;
		s_rd(OFS_CTRL_THREE) |=> (regRdData & 8'h24) == 8'h00;
	endproperty
	a_ctrlRsvd: assert property (p_ctrlRsvd) else $error("reserved control bits read nonzero");
	property p_rxRo;
		s_rd(OFS_FLAGS_ONE) ##0 $stable(periphEv.rxBufFull) |=> regRdData[BIT_RX] == $past(periphEv.rxBufFull);
	endproperty
	a_rxRo: assert property (p_rxRo) else $error("receive flag does not follow buffer");
	property p_txRo;
		s_rd(OFS_FLAGS_ONE) ##0 $stable(periphEv.txBufEmpty) |=> regRdData[BIT_TX] == $past(periphEv.txBufEmpty);
	endproperty
	a_txRo: assert property (p_txRo) else $error("transmit flag does not follow buffer");
	property p_conv;
		s_evEn(periphEv.convDone, BIT_CONV) |=> reqPending[BIT_CONV];
	endproperty
	a_conv: assert property (p_conv) else $error("conversion event lost");
	property p_sync;
		s_evEn(periphEv.syncSerialDone, BIT_SSP) |=> reqPending[BIT_SSP];
	endproperty
	a_sync: assert property (p_sync) else $error("sync serial event lost");
	property p_tmrB;
		s_evEn(periphEv.timerBMatch, BIT_TMRB) |=> reqPending[BIT_TMRB];
	endproperty
	a_tmrB: assert property (p_tmrB) else $error("timer b match lost");
	property p_tmrA;
		s_evEn(periphEv.timerAOverflow, BIT_TMRA) |=> reqPending[BIT_TMRA];
	endproperty
	a_tmrA: assert property (p_tmrA) else $error("timer a overflow lost");
	property p_mask;
		(reqPending[7:0] & ~$past(periphEnable)) == 8'h00;
	endproperty
	a_mask: assert property (p_mask) else $error("request without enable");
	property p_tag;
		(reqHigh[7:0] & ~$past(periphPriority)) == 8'h00 && (reqHigh & ~reqPending) == 10'h000;
	endproperty
	a_tag: assert property (p_tag) else $error("priority tag wrong");
	property p_high;
		|reqHigh |-> coreIrqHigh;
	endproperty
	a_high: assert property (p_high) else $error("high request not raised");
	property p_low;
		coreIrqLow |-> |(reqPending & ~reqHigh);
	endproperty
	a_low: assert property (p_low) else $error("low request without low source");
	property p_vec;
		vectorAddr == ((coreIrqLow && !coreIrqHigh) ? VEC_LOW : VEC_HIGH);
	endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");
endmodule : eapi_flags_monitor
bind eapi_flags eapi_flags_monitor u_mon (.ref_clk, .arst_n, .regAddr, .regRdStb, .regRdData, .periphEv,
	.periphEnable, .periphPriority, .reqPending, .reqHigh, .coreIrqHigh, .coreIrqLow, .vectorAddr);
`default_nettype wire

/* File: testbench/eapi_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eapi_far_model
	import eapi_pkg::*;
(
	input wire logic           ref_clk,
	output var eapi_periph_ev_t periphEv,
	output var logic           extLineA,
	output var logic           extLineB
);
	// transmit buffer starts empty, as after power-up
	initial
	begin
		periphEv = 9'h020;
		extLineA = 1'b0;
		extLineB = 1'b0;
	end
	// one-cycle event pulse from a peripheral
	task automatic pulse(input int i);
		@(posedge ref_clk);
		periphEv[i] <= 1'b1;
		@(posedge ref_clk);
		periphEv[i] <= 1'b0;
	endtask : pulse
	task automatic level(input int i, input logic v);
		@(posedge ref_clk);
		periphEv[i] <= v;
	endtask : level
	task automatic pin(input bit b, input logic v);
		@(posedge ref_clk);
		if (b)
			extLineB <= v;
		else
			extLineA <= v;
	endtask : pin
endmodule : eapi_far_model
`default_nettype wire

/* File: testbench/eapi_flags_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module eapi_flags_tb import eapi_pkg::*;;
	logic            ref_clk, arst_n, regWrStb, regRdStb, extLineA, extLineB, coreIrqHigh, coreIrqLow;
	logic [7:0]      regAddr, regWrData, regRdData, periphEnable, periphPriority;
	logic [9:0]      reqPending, reqHigh;
	logic [23:0]     vectorAddr;
	eapi_periph_ev_t periphEv;
	int              fails, samplesChecked;
	eapi_flags u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .extLineA(extLineA),
		.extLineB(extLineB), .periphEv(periphEv), .periphEnable(periphEnable), .periphPriority(periphPriority),
		.reqPending(reqPending), .reqHigh(reqHigh), .coreIrqHigh(coreIrqHigh), .coreIrqLow(coreIrqLow),
		.vectorAddr(vectorAddr));
	eapi_far_model u_far (.ref_clk(ref_clk), .periphEv(periphEv), .extLineA(extLineA), .extLineB(extLineB));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1;
		`CHK(nm, e, regRdData)
	endtask : rd
	task automatic t_regs();
		rd(OFS_CONFIG, 8'h06, "config reset");
		rd(OFS_CTRL_THREE, 8'hC0, "ctrl reset");
		wr(OFS_CTRL_THREE, 8'hFF);
		rd(OFS_CTRL_THREE, 8'hDB, "ctrl reserved");
		wr(OFS_CTRL_THREE, 8'h00);
		rd(OFS_CTRL_THREE, 8'h00, "ctrl cleared");
		wr(8'h07, 8'hFF);
		rd(8'h07, 8'h00, "unmapped");
	endtask : t_regs
	task automatic t_ext();
		wr(OFS_CONFIG, 8'h02);
		// edge-select change alone fakes no edge; a few cycles pass before clearing anyway
		repeat (4) @(posedge ref_clk);
		wr(OFS_CTRL_THREE, 8'h58);
		u_far.pin(0, 1'b1);
		u_far.pin(1, 1'b1);
		repeat (6) @(posedge ref_clk);
		rd(OFS_CTRL_THREE, 8'h59, "rise only a");
		u_far.pin(1, 1'b0);
		repeat (6) @(posedge ref_clk);
		rd(OFS_CTRL_THREE, 8'h5B, "fall b");
		`CHK("ext pending", 2'b11, reqPending[9:8])
		`CHK("ext tags", 2'b01, reqHigh[9:8])
		wr(OFS_CTRL_THREE, 8'h40);
		rd(OFS_CTRL_THREE, 8'h40, "ext cleared");
	endtask : t_ext
	task automatic t_mask();
		u_far.pulse(0);
		rd(OFS_FLAGS_ONE, 8'h11, "masked flag");
		`CHK("masked req", 1'b0, reqPending[0])
		@(posedge ref_clk);
		periphEnable <= 8'h01;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK("compat high", 1'b1, coreIrqHigh)
		`CHK("compat vec", VEC_HIGH, vectorAddr)
		wr(OFS_CONFIG, 8'h03);
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK("prio low", 2'b01, {coreIrqHigh, coreIrqLow})
		`CHK("prio vec", VEC_LOW, vectorAddr)
		rd(OFS_STATUS, 8'h04, "status low");
		@(posedge ref_clk);
		periphPriority <= 8'h01;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK("prio high", 2'b10, {coreIrqHigh, coreIrqLow})
		`CHK("high tag", 1'b1, reqHigh[0])
		`CHK("high vec", VEC_HIGH, vectorAddr)
		@(posedge ref_clk);
		periphPriority <= 8'h00;
		wr(OFS_CONFIG, 8'h02);
		wr(OFS_FLAGS_ONE, 8'h00);
		rd(OFS_FLAGS_ONE, 8'h10, "flag cleared");
	endtask : t_mask
	task automatic t_events();
		int         src[8] = '{8, 7, 4, 1, 0, 3, 2, 3};
		logic [7:0] cfg[8] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h0A, 8'h1A};
		logic [7:0] exp[8] = '{8'h90, 8'h50, 8'h18, 8'h12, 8'h11, 8'h14, 8'h14, 8'h10};
		@(posedge ref_clk);
		periphEnable <= 8'hFF;
		foreach (src[i])
		begin
			wr(OFS_CONFIG, cfg[i]);
			u_far.pulse(src[i]);
			rd(OFS_FLAGS_ONE, exp[i], "event flag");
			wr(OFS_FLAGS_ONE, 8'h00);
		end
		fork
			u_far.pulse(7);
			wr(OFS_FLAGS_ONE, 8'h00);
		join
		rd(OFS_FLAGS_ONE, 8'h50, "set beats clear");
		wr(OFS_FLAGS_ONE, 8'h00);
	endtask : t_events
	task automatic t_buffers();
		u_far.level(6, 1'b1);
		wr(OFS_FLAGS_ONE, 8'h00);
		rd(OFS_FLAGS_ONE, 8'h30, "rx full");
		u_far.level(6, 1'b0);
		u_far.level(5, 1'b0);
		wr(OFS_FLAGS_ONE, 8'h30);
		rd(OFS_FLAGS_ONE, 8'h00, "buffers ro");
	endtask : t_buffers
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		give_verdict();
	end
	initial
	begin
		{arst_n, regWrStb, regRdStb, regAddr, regWrData, periphEnable, periphPriority} = '0;
		fails = 0;
		samplesChecked = 0;
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_regs();
		t_ext();
		t_mask();
		t_events();
		t_buffers();
		give_verdict();
	end
endmodule : eapi_flags_tb
`default_nettype wire
